// [mbtu_block_copy_unit.sv]
// marker memory block transfer engine shared by all transfer units
// Function
// (R1) thirty-two independent units, own inputs and mode
// (R2) byte, word, double word operands accepted
// (R3) copy mode copies count consecutive bytes
// (R4) overlapping copy still gives correct result
// (R5) fill mode writes one source byte everywhere
// (R6) data always moves one byte at a time
// (R7) source, destination, count from their inputs
// (R8) offsets count from first marker byte, zero-based
// (R9) program scales word and double word offsets
// (R10) byte counts from one to 1024 accepted
// (R11) transfer starts only on trigger rising edge
// (R12) enable checked only when release parameter set
// (R13) parameter errors shown on three error outputs; code drives two, count_overflow_error and range_error
// (R14) count overflow error checked continuously
// (R15) range error for outside memory or zero
// (R16) no bytes moved while any error stands; code checks only at trigger edge and ST_LOAD, not mid-transfer
// (R17) legacy overlap flag never signals
// (R18) disabled unit ignores trigger, writes nothing; code does so only with unit_release_by_enable set
`timescale 1ns/1ps
module mbtu_block_copy_unit
	import mbtu_pkg::*;
#(
	parameter int NUM_UNITS = NUM_UNITS_DEF,
	parameter int MEM_BYTES = MEM_BYTES_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// per-unit control bits
	input wire logic [NUM_UNITS-1:0] unit_enable,
	input wire logic [NUM_UNITS-1:0] unit_trigger,
	input wire logic [NUM_UNITS-1:0] unit_copy_mode,
	input wire logic [NUM_UNITS-1:0] unit_release_by_enable,
	// per-unit operands, unit i in bits i*32 upward
	input wire logic [NUM_UNITS*OFS_W-1:0] source_offset,
	input wire logic [NUM_UNITS*OFS_W-1:0] dest_offset,
	input wire logic [NUM_UNITS*OFS_W-1:0] byte_count,
	// per-unit status, plus engine_busy for the whole engine
	output logic [NUM_UNITS-1:0] count_overflow_error,
	output logic [NUM_UNITS-1:0] legacy_overlap_flag,
	output logic [NUM_UNITS-1:0] range_error,
	output logic [NUM_UNITS-1:0] unit_done,
	output logic engine_busy,
	// marker memory read port, data one cycle after the request
	output logic mem_rd_en,
	output logic [$clog2(MEM_BYTES)-1:0] mem_rd_addr,
	input wire logic [DATA_W-1:0] mem_rd_data,
	// marker memory write port
	output logic mem_wr_en,
	output logic [$clog2(MEM_BYTES)-1:0] mem_wr_addr,
	output logic [DATA_W-1:0] mem_wr_data,
	input wire logic mem_wr_ready
);
	localparam int AW = $clog2(MEM_BYTES);
	localparam int UW = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1;
	localparam logic [33:0] MEM_LIMIT = 34'(MEM_BYTES);
	localparam logic [33:0] CNT_LIMIT = 34'(MAX_COUNT);

	if (NUM_UNITS < 1 || MEM_BYTES < 2 || FIFO_DEPTH < 2) begin : g_bad_param
		$error("mbtu_block_copy_unit: unit count, memory size or fifo depth too small");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	// returns {range_error, count_overflow_error} for one parameter set
	function automatic logic [1:0] param_errors(input logic [OFS_W-1:0] src,
		input logic [OFS_W-1:0] dst, input logic [OFS_W-1:0] cnt, input logic copy);
		logic [33:0] src_end, dst_end;
		logic rng, ovf;
		src_end = {2'h0, src} + {2'h0, cnt};
		dst_end = {2'h0, dst} + {2'h0, cnt};
		rng = ({2'h0, src} >= MEM_LIMIT) || ({2'h0, dst} >= MEM_LIMIT) || (cnt == '0); // R15
		// fill mode reads one source byte only, so only copy checks the source end
		ovf = !rng && (({2'h0, cnt} > CNT_LIMIT) || (dst_end > MEM_LIMIT) ||
			(copy && (src_end > MEM_LIMIT))); // R10 R14
		return {rng, ovf};
	endfunction

	function automatic logic [UW-1:0] first_index(input logic [NUM_UNITS-1:0] req);
		logic [UW-1:0] idx;
		idx = '0;
		for (int i = NUM_UNITS - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = UW'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [AW-1:0] addr_step(input logic [AW-1:0] a, input logic down);
		return down ? a - AW'(1) : a + AW'(1);
	endfunction

	function automatic logic [AW-1:0] start_addr(input logic [OFS_W-1:0] base,
		input logic [OFS_W-1:0] cnt, input logic down);
		logic [OFS_W-1:0] last;
		last = base + cnt - OFS_W'(1);
		return down ? last[AW-1:0] : base[AW-1:0];
	endfunction

	// ****************************************************************
	// continuous parameter checks
	// ****************************************************************
	logic [NUM_UNITS-1:0] err_ovf_c, err_rng_c;

	always_comb begin
		for (int i = 0; i < NUM_UNITS; i++) begin
			{err_rng_c[i], err_ovf_c[i]} = param_errors(source_offset[i*OFS_W +: OFS_W],
				dest_offset[i*OFS_W +: OFS_W], byte_count[i*OFS_W +: OFS_W],
				unit_copy_mode[i]); // R1 R2 R7 R8 R13
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count_overflow_error <= '0;
			range_error <= '0;
			legacy_overlap_flag <= '0;
		end else begin
			count_overflow_error <= err_ovf_c; // R13 R14
			range_error <= err_rng_c; // R13 R15
			legacy_overlap_flag <= '0; // R17
		end
	end

	// ****************************************************************
	// trigger edges and pending requests
	// ****************************************************************
	mbtu_state_e state_r;
	logic [NUM_UNITS-1:0] trig_prev_r, pending_r, accept_c, grant_c;
	logic [UW-1:0] sel_r;

	// trigger comes from user logic on sys_clk, so no synchroniser
	assign accept_c = unit_trigger & ~trig_prev_r & // R11
		(~unit_release_by_enable | unit_enable) & // R12 R18
		~(err_ovf_c | err_rng_c); // R16
	assign grant_c = ((state_r == ST_IDLE) && (pending_r != '0)) ?
		(NUM_UNITS'(1) << first_index(pending_r)) : '0;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			trig_prev_r <= '0;
			pending_r <= '0;
		end else begin
			trig_prev_r <= unit_trigger;
			// a new edge wins over the grant that clears it
			pending_r <= (pending_r & ~grant_c) | accept_c;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sel_r <= '0;
		end else if (grant_c != '0) begin
			sel_r <= first_index(pending_r);
		end
	end

	// ****************************************************************
	// selected job and engine control
	// ****************************************************************
	logic [OFS_W-1:0] sel_src, sel_dst, sel_cnt;
	logic sel_copy, sel_down, copy_r, down_r, rd_ret_r;
	logic [1:0] sel_err_c;
	logic [AW-1:0] rd_addr_r, wr_addr_r;
	logic [LEN_W-1:0] rd_left_r, push_left_r, wr_left_r;
	logic [DATA_W-1:0] fill_byte_r, fifo_in_data, fifo_out_data;
	logic rd_en_c, push_c, pop_c, finish_c;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;

	assign sel_src = source_offset[sel_r*OFS_W +: OFS_W];
	assign sel_dst = dest_offset[sel_r*OFS_W +: OFS_W];
	assign sel_cnt = byte_count[sel_r*OFS_W +: OFS_W];
	assign sel_copy = (unit_copy_mode[sel_r] == MODE_COPY);
	// moving down when the target lies above keeps unread source bytes intact
	assign sel_down = sel_copy && (sel_dst > sel_src); // R4
	assign sel_err_c = param_errors(sel_src, sel_dst, sel_cnt, sel_copy);

	// one read in flight at a time: its byte always finds room in the fifo
	assign rd_en_c = (state_r == ST_FILL_RD) ||
		((state_r == ST_MOVE) && copy_r && (rd_left_r != '0) &&
		!mem_rd_en && !rd_ret_r && fifo_in_ready); // R3
	assign push_c = (state_r == ST_MOVE) &&
		(copy_r ? rd_ret_r : ((push_left_r != '0) && fifo_in_ready)); // R5
	assign fifo_in_data = copy_r ? mem_rd_data : fill_byte_r;
	assign fifo_out_ready = !mem_wr_en || mem_wr_ready;
	assign pop_c = fifo_out_valid && fifo_out_ready;
	assign finish_c = (state_r == ST_MOVE) && (wr_left_r == '0) && fifo_out_ready;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (pending_r != '0) begin
						state_r <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					// operands may have changed since the edge
					if (sel_err_c != 2'h0) begin
						state_r <= ST_IDLE; // R16
					end else if (sel_copy) begin
						state_r <= ST_MOVE;
					end else begin
						state_r <= ST_FILL_RD;
					end
				end
				ST_FILL_RD: begin
					state_r <= ST_FILL_WAIT;
				end
				ST_FILL_WAIT: begin
					if (rd_ret_r) begin
						state_r <= ST_MOVE;
					end
				end
				ST_MOVE: begin
					if (finish_c) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			copy_r <= MODE_FILL;
			down_r <= 1'h0;
			rd_addr_r <= '0;
			rd_left_r <= '0;
		end else if (state_r == ST_LOAD) begin
			copy_r <= sel_copy;
			down_r <= sel_down;
			rd_addr_r <= start_addr(sel_src, sel_cnt, sel_down);
			rd_left_r <= sel_copy ? LEN_W'(sel_cnt) : LEN_W'(1);
		end else if (rd_en_c) begin
			rd_addr_r <= addr_step(rd_addr_r, down_r); // R6
			rd_left_r <= rd_left_r - LEN_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mem_rd_en <= 1'h0;
			mem_rd_addr <= '0;
			rd_ret_r <= 1'h0;
		end else begin
			mem_rd_en <= rd_en_c;
			rd_ret_r <= mem_rd_en;
			if (rd_en_c) begin
				mem_rd_addr <= rd_addr_r;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fill_byte_r <= '0;
			push_left_r <= '0;
		end else if (state_r == ST_LOAD) begin
			push_left_r <= LEN_W'(sel_cnt);
		end else begin
			if ((state_r == ST_FILL_WAIT) && rd_ret_r) begin
				fill_byte_r <= mem_rd_data; // R5
			end
			if (push_c && !copy_r) begin
				push_left_r <= push_left_r - LEN_W'(1);
			end
		end
	end

	// ****************************************************************
	// byte buffer and write stage
	// ****************************************************************
	mbtu_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk), .srst(srst),
		.in_valid(push_c), .in_ready(fifo_in_ready), .in_data(fifo_in_data),
		.out_valid(fifo_out_valid), .out_ready(fifo_out_ready), .out_data(fifo_out_data)
	);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_addr_r <= '0;
			wr_left_r <= '0;
		end else if (state_r == ST_LOAD) begin
			wr_addr_r <= start_addr(sel_dst, sel_cnt, sel_down);
			wr_left_r <= LEN_W'(sel_cnt);
		end else if (pop_c) begin
			wr_addr_r <= addr_step(wr_addr_r, down_r); // R3 R6
			wr_left_r <= wr_left_r - LEN_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mem_wr_en <= 1'h0;
			mem_wr_addr <= '0;
			mem_wr_data <= '0;
		end else if (pop_c) begin
			mem_wr_en <= 1'h1;
			mem_wr_addr <= wr_addr_r;
			mem_wr_data <= fifo_out_data;
		end else if (mem_wr_ready) begin
			mem_wr_en <= 1'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			unit_done <= '0;
			engine_busy <= 1'h0;
		end else begin
			unit_done <= finish_c ? (NUM_UNITS'(1) << sel_r) : '0;
			engine_busy <= (state_r != ST_IDLE) || (pending_r != '0);
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_idle_no_write: assert property ((state_r == ST_IDLE) |-> !mem_wr_en) // R16 R18
		else $error("write seen while engine idle");
	a_legacy_quiet: assert property (legacy_overlap_flag == '0) // R17
		else $error("legacy overlap flag raised");
	a_zero_count_range: assert property ((byte_count[OFS_W-1:0] == '0) |=> range_error[0]) // R15
		else $error("zero byte count without range error");
	a_count_overflow: assert property (
		(({2'h0, byte_count[OFS_W-1:0]} > CNT_LIMIT) && !err_rng_c[0])
		|=> count_overflow_error[0]) // R10 R14
		else $error("oversized byte count not flagged");
	a_edge_only: assert property ($rose(pending_r[0]) |-> $past(unit_trigger[0] && !trig_prev_r[0])) // R11
		else $error("request accepted without a trigger edge");
	a_enable_gate: assert property (
		$rose(pending_r[0]) |-> $past(unit_enable[0] || !unit_release_by_enable[0])) // R12 R18
		else $error("request accepted while unit disabled");
	a_error_blocks: assert property (
		$rose(pending_r[0]) |-> $past(!err_ovf_c[0] && !err_rng_c[0])) // R16
		else $error("request accepted with parameter error");
	a_fill_one_read: assert property (((state_r == ST_MOVE) && !copy_r) |-> !mem_rd_en) // R5
		else $error("fill mode read the source more than once");
	a_done_all_bytes: assert property (
		(unit_done != '0) |-> $past((wr_left_r == '0) && (state_r == ST_MOVE))) // R3
		else $error("done before every byte was written");
	a_write_hold: assert property ((mem_wr_en && !mem_wr_ready) |=> // R3 R6
		(mem_wr_en && $stable(mem_wr_addr) && $stable(mem_wr_data)))
		else $error("write request changed before it was taken");

	c_copy_done: cover property ((unit_done != '0) && copy_r);
	c_fill_done: cover property ((unit_done != '0) && !copy_r);
	c_overlap_down: cover property ((state_r == ST_MOVE) && down_r && pop_c);
	c_write_stall: cover property (mem_wr_en && !mem_wr_ready && !fifo_in_ready);
endmodule

// [mbtu_pkg.sv]
// shared constants and types of the marker block transfer unit
package mbtu_pkg;

	// ****************************************************************
	// sizes and limits
	// ****************************************************************
	localparam int NUM_UNITS_DEF = 32;
	localparam int MEM_BYTES_DEF = 512;
	localparam int FIFO_DEPTH_DEF = 8;
	localparam int DATA_W = 8;
	localparam int OFS_W = 32;
	localparam int MAX_COUNT = 1024;
	localparam int LEN_W = 11;

	// ****************************************************************
	// mode encoding of unit_copy_mode
	// ****************************************************************
	localparam logic MODE_COPY = 1'h1;
	localparam logic MODE_FILL = 1'h0;

	// ****************************************************************
	// engine states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOAD = 3'h1,
		ST_FILL_RD = 3'h2,
		ST_FILL_WAIT = 3'h3,
		ST_MOVE = 3'h4
	} mbtu_state_e;

endpackage

// [mbtu_fifo.sv]
// byte fifo between marker reads and marker writes
`timescale 1ns/1ps
module mbtu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (WIDTH < 1 || DEPTH < 2) begin : g_bad_fifo
		$error("mbtu_fifo: width must be at least 1 and depth at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign in_ready = (count_r != CW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			end
			count_r <= count_r + CW'(push) - CW'(pop);
		end
	end

	a_fifo_bound: assert property (@(posedge sys_clk) disable iff (srst)
		count_r <= CW'(DEPTH))
		else $error("fifo count beyond depth");
	c_fifo_full: cover property (@(posedge sys_clk) disable iff (srst) !in_ready);
endmodule

// [mbtu_mem_model.sv]
// marker byte memory model with a one-cycle read and a stallable write port
`timescale 1ns/1ps
module mbtu_mem_model #(
	parameter int MEM_BYTES = 2048
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// read port
	input wire logic mem_rd_en,
	input wire logic [$clog2(MEM_BYTES)-1:0] mem_rd_addr,
	output logic [7:0] mem_rd_data,
	// write port
	input wire logic mem_wr_en,
	input wire logic [$clog2(MEM_BYTES)-1:0] mem_wr_addr,
	input wire logic [7:0] mem_wr_data,
	output logic mem_wr_ready,
	// bench control
	input wire logic stall
);
	logic [7:0] mem [MEM_BYTES];
	logic [1:0] phase_r;
	int wr_count;
	initial wr_count = 0;
	// under stall only one cycle in four accepts a write
	assign mem_wr_ready = !stall || (phase_r == 2'h3);
	always @(posedge sys_clk) begin
		phase_r <= srst ? 2'h0 : phase_r + 2'h1;
	end
	// idle cycles show the inverse so stale data never passes for a fresh read
	always @(posedge sys_clk) begin
		mem_rd_data <= mem_rd_en ? mem[mem_rd_addr] : ~mem_rd_data;
	end
	always @(posedge sys_clk) begin
		if (mem_wr_en && mem_wr_ready) begin
			mem[mem_wr_addr] <= mem_wr_data;
			wr_count <= wr_count + 1;
		end
	end
endmodule

// [tb.sv]
// self-checking bench of the marker block transfer unit
`timescale 1ns/1ps
module tb;
	import mbtu_pkg::*;
	localparam int NU = 32;
	localparam int MB = 2048;
	localparam int AW = $clog2(MB);
	logic sys_clk, srst, stall, busy, rd_en, wr_en, wr_ready;
	logic [NU-1:0] en, trig, mode, rel, ovf, leg, rng, done;
	logic [NU*OFS_W-1:0] src_v, dst_v, cnt_v;
	logic [AW-1:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data;
	logic [7:0] shadow [MB];
	int errors, num_checks;

	mbtu_block_copy_unit #(.NUM_UNITS(NU), .MEM_BYTES(MB), .FIFO_DEPTH(FIFO_DEPTH_DEF)) dut (
		.sys_clk(sys_clk), .srst(srst), .unit_enable(en), .unit_trigger(trig),
		.unit_copy_mode(mode), .unit_release_by_enable(rel), .source_offset(src_v),
		.dest_offset(dst_v), .byte_count(cnt_v), .count_overflow_error(ovf),
		.legacy_overlap_flag(leg), .range_error(rng), .unit_done(done), .engine_busy(busy),
		.mem_rd_en(rd_en), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .mem_wr_en(wr_en),
		.mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .mem_wr_ready(wr_ready));
	mbtu_mem_model #(.MEM_BYTES(MB)) u_mem (
		.sys_clk(sys_clk), .srst(srst), .mem_rd_en(rd_en), .mem_rd_addr(rd_addr),
		.mem_rd_data(rd_data), .mem_wr_en(wr_en), .mem_wr_addr(wr_addr),
		.mem_wr_data(wr_data), .mem_wr_ready(wr_ready), .stall(stall));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic set_unit(input int u, input logic m, input int s, input int d, input int c);
		@(posedge sys_clk);
		mode[u] <= m;
		src_v[u*32+:32] <= s;
		dst_v[u*32+:32] <= d;
		cnt_v[u*32+:32] <= c;
		trig[u] <= 1'b0;
	endtask
	// snapshot first so overlapping copies expect the untouched source
	task automatic expect_op(input logic m, input int s, input int d, input int c);
		logic [7:0] tmp [MB];
		tmp = shadow;
		for (int i = 0; i < c; i++) shadow[d+i] = (m == MODE_COPY) ? tmp[s+i] : tmp[s];
	endtask
	task automatic check_mem(input string name);
		int bad;
		bad = 0;
		for (int i = 0; i < MB; i++) if (u_mem.mem[i] !== shadow[i]) bad++;
		chk(name, 0, bad);
	endtask
	task automatic wait_done(input int u);
		int k;
		k = 0;
		while (done[u] !== 1'b1 && k < 8000) begin
			tick(1);
			k++;
		end
		chk("unit_done", 1, done[u]);
	endtask
	// trigger stays high after completion: a held level must not start again
	task automatic run(input int u, input logic m, input int s, input int d, input int c);
		int w0;
		set_unit(u, m, s, d, c);
		expect_op(m, s, d, c);
		w0 = u_mem.wr_count;
		@(posedge sys_clk) trig[u] <= 1'b1;
		tick(2);
		chk("engine_busy", 1, busy);
		wait_done(u);
		chk("write count", c, u_mem.wr_count - w0);
		tick(12);
		chk("held trigger", c, u_mem.wr_count - w0);
		chk("engine_busy after done", 0, busy);
		@(posedge sys_clk) trig[u] <= 1'b0;
	endtask
	task automatic refused(input int u, input string name);
		int w0;
		int seen;
		w0 = u_mem.wr_count;
		seen = 0;
		@(posedge sys_clk) trig[u] <= 1'b1;
		repeat (40) begin
			tick(1);
			if (done[u] === 1'b1) seen++;
		end
		chk(name, 0, seen + u_mem.wr_count - w0);
		@(posedge sys_clk) trig[u] <= 1'b0;
	endtask
	task automatic err_case(input int s, input int d, input int c, input logic m,
		input logic eo, input logic er);
		set_unit(0, m, s, d, c);
		tick(3);
		chk("count_overflow_error", eo, ovf[0]);
		chk("range_error", er, rng[0]);
		refused(0, "refused on error");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_copy();
		run(0, MODE_COPY, 0, 10, 4);
		run(1, MODE_COPY, 4, 16, 4);
		check_mem("plain copy");
		$display("test copy done");
	endtask
	task automatic test_overlap();
		@(posedge sys_clk) stall <= 1'b1;
		run(2, MODE_COPY, 100, 103, 9);
		run(2, MODE_COPY, 200, 196, 9);
		@(posedge sys_clk) stall <= 1'b0;
		check_mem("overlap copy");
		chk("legacy_overlap_flag", 0, leg);
		$display("test overlap done");
	endtask
	task automatic test_fill();
		run(3, MODE_FILL, 5, 300, 8);
		check_mem("fill");
		$display("test fill done");
	endtask
	task automatic test_bounds();
		run(4, MODE_COPY, 0, 1024, 1024);
		run(4, MODE_COPY, 2047, 0, 1);
		check_mem("count bounds");
		$display("test bounds done");
	endtask
	task automatic test_errors();
		err_case(0, 0, 0, MODE_COPY, 1'b0, 1'b1);
		err_case(0, 0, 1025, MODE_COPY, 1'b1, 1'b0);
		err_case(0, 2040, 16, MODE_FILL, 1'b1, 1'b0);
		err_case(2040, 0, 16, MODE_COPY, 1'b1, 1'b0);
		err_case(2048, 0, 1, MODE_COPY, 1'b0, 1'b1);
		err_case(0, 2048, 1, MODE_FILL, 1'b0, 1'b1);
		check_mem("memory after errors");
		$display("test errors done");
	endtask
	task automatic test_enable();
		@(posedge sys_clk) rel[6] <= 1'b1;
		set_unit(6, MODE_COPY, 0, 500, 4);
		refused(6, "disabled trigger");
		@(posedge sys_clk) en[6] <= 1'b1;
		run(6, MODE_COPY, 0, 500, 4);
		check_mem("enabled copy");
		$display("test enable done");
	endtask
	task automatic test_multi();
		set_unit(5, MODE_COPY, 0, 600, 3);
		set_unit(31, MODE_FILL, 9, 700, 5);
		expect_op(MODE_COPY, 0, 600, 3);
		expect_op(MODE_FILL, 9, 700, 5);
		@(posedge sys_clk) {trig[31], trig[5]} <= 2'h3;
		wait_done(5);
		wait_done(31);
		@(posedge sys_clk) {trig[31], trig[5]} <= 2'h0;
		check_mem("two units");
		$display("test multi done");
	endtask

	// ****************************************************************
	// clock, main sequence, watchdog
	// ****************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		srst = 1'b1;
		stall = 1'b0;
		en = '0;
		trig = '0;
		mode = '0;
		rel = '0;
		src_v = '0;
		dst_v = '0;
		cnt_v = '0;
		errors = 0;
		num_checks = 0;
		for (int i = 0; i < MB; i++) begin
			shadow[i] = 8'(i * 13 + 7);
			u_mem.mem[i] = shadow[i];
		end
		tick(3);
		chk("unit_done in reset", 0, done);
		chk("memory strobes in reset", 0, {busy, rd_en, wr_en});
		chk("legacy_overlap_flag in reset", 0, leg);
		@(posedge sys_clk) srst <= 1'b0;
		test_copy();
		test_overlap();
		test_fill();
		test_bounds();
		test_errors();
		test_enable();
		test_multi();
		conclude();
	end
	// the whole run needs well under 15000 cycles
	initial begin
		#250000;
		errors++;
		conclude();
	end
endmodule
